/* design/rcc_ready_timer.sv */
// ready delay timer after oscillator start
`timescale 1ns/1ps
`default_nettype none
module rcc_ready_timer
    import rcc_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // link to register logic
    rcc_timer_if.timer tif
);
    rcc_tstate_type state_reg, state_next;
    logic [5:0] ripple_reg, ripple_next;
    logic [8:0] exp_reg, exp_next;
    logic [8:0] target_reg, target_next;
    logic ready_low_reg, ready_low_next;
    logic settled_reg, settled_next;
    logic [15:0] wait_cnt_reg, wait_cnt_next;
    logic [8:0] sel_target;

    always_comb begin
        case (tif.sel)
            2'b00: sel_target = RCC_EXPIRE_SEL0;
            2'b01: sel_target = RCC_EXPIRE_SEL1;
            2'b10: sel_target = RCC_EXPIRE_SEL2;
            default: sel_target = RCC_EXPIRE_SEL3;
        endcase
        state_next = state_reg;
        ripple_next = ripple_reg;
        exp_next = exp_reg;
        target_next = target_reg;
        ready_low_next = 1'b1;
        settled_next = 1'b0;
        wait_cnt_next = 16'h0000;
        if (!tif.start) begin
            state_next = RCC_T_IDLE;
        end else begin
            case (state_reg)
                RCC_T_IDLE: begin
                    state_next = RCC_T_WAIT;
                    ripple_next = 6'h00;
                    exp_next = 9'h000;
                    target_next = sel_target;
                end
                RCC_T_WAIT: begin
                    wait_cnt_next = wait_cnt_reg + 16'h0001;
                    ripple_next = ripple_reg + 6'h01;
                    if (ripple_reg == RCC_RIPPLE_MAX) begin
                        exp_next = exp_reg + 9'h001;
                        if (exp_next == target_reg) begin
                            state_next = RCC_T_READY;
                            // both indications change together
                            ready_low_next = 1'b0;
                            settled_next = 1'b1;
                        end
                    end
                end
                RCC_T_READY: begin
                    ready_low_next = 1'b0;
                    settled_next = 1'b1;
                end
                default: begin
                    state_next = RCC_T_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_reg <= RCC_T_IDLE;
            ripple_reg <= 6'h00;
            exp_reg <= 9'h000;
            target_reg <= RCC_EXPIRE_SEL1;
            ready_low_reg <= 1'b1;
            settled_reg <= 1'b0;
            wait_cnt_reg <= 16'h0000;
        end else begin
            state_reg <= state_next;
            ripple_reg <= ripple_next;
            exp_reg <= exp_next;
            target_reg <= target_next;
            ready_low_reg <= ready_low_next;
            settled_reg <= settled_next;
            wait_cnt_reg <= wait_cnt_next;
        end
    end

    assign tif.ready_low = ready_low_reg;
    assign tif.settled = settled_reg;

    sequence settle_rise_s;
        $rose(settled_reg);
    endsequence

    ready_flag_same_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        ready_low_reg == !settled_reg)
        else $error("ready and settled indications differ");

    delay_length_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        settle_rise_s |-> (wait_cnt_reg == {1'b0, target_reg, 6'h00}))
        else $error("ready delay not sixty-four times expire count");

    ripple_expire_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (state_reg == RCC_T_WAIT) && (ripple_reg != RCC_RIPPLE_MAX) && tif.start
        |=> (exp_reg == $past(exp_reg)) && !settled_reg)
        else $error("expiration counted before ripple wrap");
endmodule
`default_nettype wire

/* design/rcc_top.sv */
// radio control config registers with ready timer and loop control
// Contract
// - delay select picks 1/16/64/256 expirations
// - count six-bit ripple wraps, then ready low
// - settled flag and ready low change together
// - keep-on bit holds oscillator in sleep
// - gate bit freezes loops until carrier sense
// - gain field selects K to 4K presync
`timescale 1ns/1ps
`default_nettype none
module rcc_top
    import rcc_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // configuration port
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    input wire logic [5:0] addr_in,
    input wire logic [7:0] wdata_in,
    output logic [7:0] rdata_out,
    // oscillator and power control
    input wire logic sleep_req_in,
    input wire logic osc_running_in,
    output logic osc_enable_out,
    output logic chip_ready_out_low,
    output logic osc_settled_flag_out,
    // demodulator loop control
    input wire logic carrier_sense_in,
    output logic loops_frozen_out,
    output logic [2:0] freq_gain_mult_out
);
    rcc_timer_if tif ();

    logic [7:0] mcsm_reg, mcsm_next;
    logic [7:0] focc_reg, focc_next;
    logic [7:0] rdata_reg, rdata_next;
    logic [1:0] s1_reg, s2_reg, s3_reg, val_reg;
    logic [1:0] val_next;
    logic osc_en_reg, osc_en_next;
    logic frozen_reg, frozen_next;
    logic [2:0] gain_reg, gain_next;
    logic keep_on, gate_on, cs_val, osc_val;
    logic [1:0] gain_sel;

    assign keep_on = mcsm_reg[RCC_KEEP_ON_BIT];
    assign gate_on = focc_reg[RCC_GATE_BIT];
    assign gain_sel = focc_reg[RCC_GAIN_MSB:RCC_GAIN_LSB];
    assign cs_val = val_reg[1];
    assign osc_val = val_reg[0];

    // register file
    always_comb begin
        mcsm_next = mcsm_reg;
        focc_next = focc_reg;
        rdata_next = rdata_reg;
        if (wr_en_in && addr_in == RCC_ADDR_MCSM) begin
            // reserved bit stored as written by host
            mcsm_next = wdata_in & RCC_WR_MASK;
        end
        if (wr_en_in && addr_in == RCC_ADDR_FOCC) begin
            focc_next = wdata_in & RCC_WR_MASK;
        end
        if (rd_en_in) begin
            case (addr_in)
                RCC_ADDR_MCSM: rdata_next = mcsm_reg & RCC_WR_MASK;
                RCC_ADDR_FOCC: rdata_next = focc_reg & RCC_WR_MASK;
                default: rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            mcsm_reg <= RCC_MCSM_RST;
            focc_reg <= RCC_FOCC_RST;
            rdata_reg <= 8'h00;
        end else begin
            mcsm_reg <= mcsm_next;
            focc_reg <= focc_next;
            rdata_reg <= rdata_next;
        end
    end

    // pin synchronisers, accepted when stages two and three agree
    always_comb begin
        val_next = val_reg;
        for (int i = 0; i < 2; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
                val_next[i] = s3_reg[i];
            end
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s1_reg <= 2'b00;
            s2_reg <= 2'b00;
            s3_reg <= 2'b00;
            val_reg <= 2'b00;
        end else begin
            s1_reg <= {carrier_sense_in, osc_running_in};
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            val_reg <= val_next;
        end
    end

    // oscillator enable and loop control
    always_comb begin
        osc_en_next = !sleep_req_in || keep_on;
        frozen_next = gate_on && !cs_val;
        gain_next = {1'b0, gain_sel} + 3'h1;
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            osc_en_reg <= 1'b1;
            frozen_reg <= 1'b1;
            gain_reg <= 3'h3;
        end else begin
            osc_en_reg <= osc_en_next;
            frozen_reg <= frozen_next;
            gain_reg <= gain_next;
        end
    end

    // timer runs while oscillator enabled and reported running
    assign tif.start = osc_en_reg && osc_val;
    assign tif.sel = mcsm_reg[RCC_DELAY_MSB:RCC_DELAY_LSB];

    rcc_ready_timer u_timer (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .tif(tif)
    );

    assign rdata_out = rdata_reg;
    assign osc_enable_out = osc_en_reg;
    assign chip_ready_out_low = tif.ready_low;
    assign osc_settled_flag_out = tif.settled;
    assign loops_frozen_out = frozen_reg;
    assign freq_gain_mult_out = gain_reg;

    sequence focc_read_s;
        rd_en_in && (addr_in == RCC_ADDR_FOCC);
    endsequence

    sequence mcsm_read_s;
        rd_en_in && (addr_in == RCC_ADDR_MCSM);
    endsequence

    keep_on_run_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        keep_on && sleep_req_in |=> osc_enable_out)
        else $error("oscillator stopped in sleep with keep-on set");

    sleep_stop_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        !keep_on && sleep_req_in |=> !osc_enable_out)
        else $error("oscillator kept running in sleep");

    keep_readback_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        mcsm_read_s |=> rdata_out[RCC_KEEP_ON_BIT] == $past(keep_on))
        else $error("keep-on bit readback wrong");

    freeze_gate_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        gate_on && !cs_val |=> loops_frozen_out)
        else $error("loops not frozen before carrier sense");

    loops_release_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (!gate_on || cs_val) |=> !loops_frozen_out)
        else $error("loops frozen without gate condition");

    gain_map_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        ##1 freq_gain_mult_out == {1'b0, $past(gain_sel)} + 3'h1)
        else $error("presync gain multiplier wrong");

    unused_bits_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        focc_read_s |=> rdata_out[7:6] == 2'b00)
        else $error("unused offset bits read nonzero");

    ready_pair_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        $fell(chip_ready_out_low) |-> $rose(osc_settled_flag_out))
        else $error("ready and settled not simultaneous");

    ready_needs_osc_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        !tif.start |=> chip_ready_out_low)
        else $error("ready low without running oscillator");
endmodule
`default_nettype wire

/* inc/rcc_pkg.sv */
// constants for the radio control configuration registers
`default_nettype none
package rcc_pkg;
    // register offsets
    localparam logic [5:0] RCC_ADDR_MCSM = 6'h18;
    localparam logic [5:0] RCC_ADDR_FOCC = 6'h19;
    // reset values
    localparam logic [7:0] RCC_MCSM_RST = 8'h04;
    localparam logic [7:0] RCC_FOCC_RST = 8'h36;
    // writable bits, bits 7:6 read as zero
    localparam logic [7:0] RCC_WR_MASK = 8'h3f;
    // state machine config fields
    localparam int RCC_KEEP_ON_BIT = 0;
    localparam int RCC_RSVD_BIT = 1;
    localparam int RCC_DELAY_LSB = 2;
    localparam int RCC_DELAY_MSB = 3;
    // offset compensation fields
    localparam int RCC_GAIN_LSB = 3;
    localparam int RCC_GAIN_MSB = 4;
    localparam int RCC_GATE_BIT = 5;
    // expiration counts per delay select
    localparam logic [8:0] RCC_EXPIRE_SEL0 = 9'h001;
    localparam logic [8:0] RCC_EXPIRE_SEL1 = 9'h010;
    localparam logic [8:0] RCC_EXPIRE_SEL2 = 9'h040;
    localparam logic [8:0] RCC_EXPIRE_SEL3 = 9'h100;
    // six-bit ripple counter terminal value
    localparam logic [5:0] RCC_RIPPLE_MAX = 6'h3f;
    // ready timer states
    typedef enum logic [1:0] {
        RCC_T_IDLE = 2'b00,
        RCC_T_WAIT = 2'b01,
        RCC_T_READY = 2'b10
    } rcc_tstate_type;
endpackage
`default_nettype wire

/* inc/rcc_timer_if.sv */
// link between register logic and ready timer
`timescale 1ns/1ps
`default_nettype none
interface rcc_timer_if;
    logic start;
    logic [1:0] sel;
    logic ready_low;
    logic settled;
    modport ctrl (output start, output sel, input ready_low, input settled);
    modport timer (input start, input sel, output ready_low, output settled);
endinterface
`default_nettype wire

/* tb/test_radio_control_config_fields.sv */
// self-checking bench for the radio control config registers
`timescale 1ns/1ps
`default_nettype none
module test_radio_control_config_fields;
    import rcc_pkg::*;
    logic clk_in, nrst_in, wr_en_in, rd_en_in;
    logic [5:0] addr_in;
    logic [7:0] wdata_in, rdata_out, d;
    logic sleep_req_in, osc_running_in, osc_enable_out;
    logic chip_ready_out_low, osc_settled_flag_out, carrier_sense_in, loops_frozen_out;
    logic [2:0] freq_gain_mult_out;
    int miscompares, check_count, cycles, m18, m19;

    rcc_top dut (
        .clk_in(clk_in), .nrst_in(nrst_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .rdata_out(rdata_out),
        .sleep_req_in(sleep_req_in), .osc_running_in(osc_running_in),
        .osc_enable_out(osc_enable_out), .chip_ready_out_low(chip_ready_out_low),
        .osc_settled_flag_out(osc_settled_flag_out), .carrier_sense_in(carrier_sense_in),
        .loops_frozen_out(loops_frozen_out), .freq_gain_mult_out(freq_gain_mult_out)
    );

    initial begin
        clk_in = 0;
        forever #50 clk_in = ~clk_in;
    end

    // hang guard, ready runs need about 22000 cycles
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 30000) begin
            miscompares++;
            summarize();
        end
    end

    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic tick;
        @(posedge clk_in);
        #10;
    endtask

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] v);
        wr_en_in = 1;
        addr_in = a;
        wdata_in = v;
        tick();
        wr_en_in = 0;
        if (a == 6'h18) m18 = v & 8'h3f;
        else if (a == 6'h19) m19 = v & 8'h3f;
    endtask

    task automatic rdchk(input logic [5:0] a);
        int e;
        e = (a == 6'h18) ? m18 : (a == 6'h19) ? m19 : 0;
        rd_en_in = 1;
        addr_in = a;
        tick();
        rd_en_in = 0;
        chk("rdata", e[7:0], rdata_out);
        // let an edge pass so a following read raises the strobe anew
        tick();
    endtask

    task automatic ready_run(input int sel);
        int n, lim;
        lim = 64 * ((sel == 0) ? 1 : (sel == 1) ? 16 : (sel == 2) ? 64 : 256);
        osc_running_in = 0;
        repeat (6) tick();
        chk("ready idle", 8'h01, {7'h0, chip_ready_out_low});
        d = 8'($urandom);
        d[3:2] = sel[1:0];
        wr(6'h18, d);
        osc_running_in = 1;
        n = 0;
        while (chip_ready_out_low === 1'b1 && n < lim + 20) begin
            tick();
            n++;
            chk("settled", {7'h0, ~chip_ready_out_low}, {7'h0, osc_settled_flag_out});
        end
        check_count++;
        if (n < lim + 3 || n > lim + 6) begin
            miscompares++;
            $display("[ERR] ready delay expected %0d seen %0d", lim + 5, n);
        end
    endtask

    initial begin
        {nrst_in, wr_en_in, rd_en_in, addr_in, wdata_in} = '0;
        {sleep_req_in, osc_running_in, carrier_sense_in} = '0;
        void'($urandom(32'hf117745b));
        m18 = 8'h04;
        m19 = 8'h36;
        repeat (10) @(posedge clk_in);
        #10;
        nrst_in = 1;
        tick();
        rdchk(6'h18);
        rdchk(6'h19);
        chk("gain", 8'h03, {5'h0, freq_gain_mult_out});
        chk("frozen", 8'h01, {7'h0, loops_frozen_out});
        chk("settled", 8'h00, {7'h0, osc_settled_flag_out});
        wr(6'h19, 8'hff);
        rdchk(6'h19);
        wr(6'h1a, 8'($urandom));
        rdchk(6'h1a);
        rdchk(6'h18);
        for (int g = 0; g < 4; g++) begin
            d = 8'($urandom);
            d[4:3] = g[1:0];
            d[5] = 1'b1;
            wr(6'h19, d);
            tick();
            chk("gain", g[7:0] + 8'h01, {5'h0, freq_gain_mult_out});
            rdchk(6'h19);
        end
        // gate set: frozen only while carrier sense is low
        repeat (6) tick();
        chk("frozen", 8'h01, {7'h0, loops_frozen_out});
        carrier_sense_in = 1;
        repeat (6) tick();
        chk("frozen", 8'h00, {7'h0, loops_frozen_out});
        carrier_sense_in = 0;
        repeat (6) tick();
        chk("frozen", 8'h01, {7'h0, loops_frozen_out});
        wr(6'h19, m19[7:0] & 8'hdf);
        tick();
        chk("frozen", 8'h00, {7'h0, loops_frozen_out});
        // sleep with and without keep-on, reserved bit random
        sleep_req_in = 1;
        for (int k = 0; k < 2; k++) begin
            d = 8'($urandom);
            d[0] = k[0];
            wr(6'h18, d);
            tick();
            chk("osc_enable", k[7:0], {7'h0, osc_enable_out});
            rdchk(6'h18);
        end
        sleep_req_in = 0;
        for (int s = 0; s < 4; s++) begin
            ready_run(s);
        end
        // reset after the last run has reached ready while the oscillator keeps running
        nrst_in = 0;
        tick();
        chk("ready reset", 8'h01, {7'h0, chip_ready_out_low});
        chk("settled reset", 8'h00, {7'h0, osc_settled_flag_out});
        nrst_in = 1;
        m18 = 8'h04;
        m19 = 8'h36;
        tick();
        rdchk(6'h18);
        rdchk(6'h19);
        chk("gain reset", 8'h03, {5'h0, freq_gain_mult_out});
        chk("frozen reset", 8'h01, {7'h0, loops_frozen_out});
        chk("ready restart", 8'h01, {7'h0, chip_ready_out_low});
        chk("settled restart", 8'h00, {7'h0, osc_settled_flag_out});
        summarize();
    end
endmodule
`default_nettype wire
